// *** rtl/tscs_sequencer.sv ***
`timescale 1ns/1ps
// Summary of operation
// - first stage and hot-swap on only when all enables, input level, no fault
// - source select 3 takes loop1 input voltage from primary sense
// - first stage PWM starts first, hot-swap enable after the delay
// - delay equals programmed value times 10 us plus 20 us
// - normal disable on off request or input below off level
// - normal disable drops hot-swap, keeps PWMs until output below stop level
// - fault shutdown drops hot-swap and all PWMs at once
// - undervoltage faults take the soft shutdown path
// - non-fault shutdown runs second stage at forced duty
// - second stage starts once midpoint reaches 3.0 V
// - forced duty is duty limit divided by 2^-8 times 100
// - forced duty recomputed at configuration load and duty limit write
// - first stage frequency follows its frequency command on every write
// - output undervoltage masked until output rises above warn limit
// - one enable controls both loops together
// - command B1h holds the hot-swap turn-on input level
// - command B2h holds the hot-swap turn-off input level
// - command E5h holds the output level where switching stops
// - command E8h holds the hot-swap turn-on delay
// - command EDh holds the first stage duty limit
// - loop0 config 1Fh uses operation and pin, loop1 1Ah operation only
module tscs_sequencer (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               converterEnablePin,
  input  wire logic               operationOn,
  input  wire logic [7:0]         onOffCfgLoop0,
  input  wire logic [7:0]         onOffCfgLoop1,
  input  wire logic [1:0]         loop1InputSourceSelect,
  input  wire tscs_pkg::tscs_sense_t sense,
  input  wire logic               faultShutdown,
  input  wire logic               inputUvFault,
  input  wire logic               voutUvRaw,
  input  wire logic               cfgLoad,
  input  wire logic [15:0]        cfgDutyLimit,
  input  wire logic               freqWrite,
  input  wire logic [15:0]        freqValue,
  input  wire logic               cmdValid,
  input  wire logic               cmdWrite,
  input  wire logic [7:0]         cmdCode,
  input  wire logic [15:0]        cmdWdata,
  output logic                    cmdAck,
  output logic                    cmdUnsupported,
  output logic [15:0]             cmdRdata,
  output tscs_pkg::tscs_drive_t   drive,
  output logic [15:0]             loop1ForcedDuty,
  output logic [15:0]             loop1Freq
);

  // ****************************************
  // helpers
  // ****************************************
  // linear11 word to unsigned volts with 8 fraction bits; negative gives 0
  function automatic logic [15:0] lin11ToQ8(input logic [15:0] w);
    logic signed [31:0] mant;
    logic signed [31:0] sh;
    logic signed [31:0] res;
    mant = 32'(signed'(w[10:0]));
    sh   = 32'(signed'(w[15:11])) + tscs_pkg::VOLT_FRAC_BITS;
    if (sh >= 0) begin
      res = mant <<< sh[4:0];
    end else begin
      res = mant >>> 5'(-sh);
    end
    if (res < 0) begin
      lin11ToQ8 = 16'h0000;
    end else if (res > 32'sh0000_FFFF) begin
      lin11ToQ8 = 16'hFFFF;
    end else begin
      lin11ToQ8 = res[15:0];
    end
  endfunction

  // ****************************************
  // command registers
  // ****************************************
  logic [15:0] onLevel_q;
  logic [15:0] offLevel_q;
  logic [15:0] stopLevel_q;
  logic [15:0] delayReg_q;
  logic [15:0] dutyLimit_q;
  logic        dutyRecalc_q;
  logic        hit;

  assign hit = cmdCode == tscs_pkg::CMD_EFUSE_ON_LEVEL
            || cmdCode == tscs_pkg::CMD_EFUSE_OFF_LEVEL
            || cmdCode == tscs_pkg::CMD_PWM_STOP_LEVEL
            || cmdCode == tscs_pkg::CMD_EFUSE_DELAY
            || cmdCode == tscs_pkg::CMD_DUTY_LIMIT;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      onLevel_q    <= tscs_pkg::RST_EFUSE_ON_LEVEL;
      offLevel_q   <= tscs_pkg::RST_EFUSE_OFF_LEVEL;
      stopLevel_q  <= tscs_pkg::RST_PWM_STOP_LEVEL;
      delayReg_q   <= tscs_pkg::RST_EFUSE_DELAY;
      dutyLimit_q  <= tscs_pkg::RST_DUTY_LIMIT;
      dutyRecalc_q <= 1'b1;
    end else begin
      dutyRecalc_q <= 1'b0;
      if (cfgLoad) begin
        dutyLimit_q  <= cfgDutyLimit;
        dutyRecalc_q <= 1'b1;
      end
      if (cmdValid && cmdWrite) begin
        unique case (cmdCode)
          tscs_pkg::CMD_EFUSE_ON_LEVEL:  onLevel_q   <= cmdWdata;
          tscs_pkg::CMD_EFUSE_OFF_LEVEL: offLevel_q  <= cmdWdata;
          tscs_pkg::CMD_PWM_STOP_LEVEL:  stopLevel_q <= cmdWdata;
          tscs_pkg::CMD_EFUSE_DELAY:     delayReg_q  <= cmdWdata;
          tscs_pkg::CMD_DUTY_LIMIT: begin
            dutyLimit_q  <= cmdWdata;
            dutyRecalc_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmdAck         <= 1'b0;
      cmdUnsupported <= 1'b0;
      cmdRdata       <= 16'h0000;
    end else begin
      cmdAck         <= cmdValid && hit;
      cmdUnsupported <= cmdValid && !hit;
      if (cmdValid && !cmdWrite) begin
        unique case (cmdCode)
          tscs_pkg::CMD_EFUSE_ON_LEVEL:  cmdRdata <= onLevel_q;
          tscs_pkg::CMD_EFUSE_OFF_LEVEL: cmdRdata <= offLevel_q;
          tscs_pkg::CMD_PWM_STOP_LEVEL:  cmdRdata <= stopLevel_q;
          tscs_pkg::CMD_EFUSE_DELAY:     cmdRdata <= delayReg_q;
          tscs_pkg::CMD_DUTY_LIMIT:      cmdRdata <= dutyLimit_q;
          default:                       cmdRdata <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // forced duty and frequency
  // ****************************************
  logic [15:0] dutyCalc;
  // q8 volts over 100 equals value over 2^-8*100
  assign dutyCalc = 16'(32'(lin11ToQ8(dutyLimit_q))
                        / tscs_pkg::DUTY_SCALE_PCT);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loop1ForcedDuty <= 16'h0000;
    end else if (dutyRecalc_q) begin
      loop1ForcedDuty <= dutyCalc;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loop1Freq <= tscs_pkg::RST_LOOP1_FREQ;
    end else if (freqWrite) begin
      loop1Freq <= freqValue;
    end
  end

  // ****************************************
  // enable decode
  // ****************************************
  logic enSync1_q;
  logic enSync2_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enSync1_q <= 1'b0;
      enSync2_q <= 1'b0;
    end else begin
      enSync1_q <= converterEnablePin;
      enSync2_q <= enSync1_q;
    end
  end

  function automatic logic loopRequest(input logic [7:0] cfg,
                                       input logic       pin,
                                       input logic       op);
    logic pinOn;
    pinOn = pin == cfg[tscs_pkg::CFG_POLARITY_BIT];
    if (!cfg[tscs_pkg::CFG_RESPOND_BIT]) begin
      loopRequest = 1'b1;
    end else begin
      loopRequest = (!cfg[tscs_pkg::CFG_USE_OP_BIT] || op)
                 && (!cfg[tscs_pkg::CFG_USE_PIN_BIT] || pinOn);
    end
  endfunction

  logic        enableRequest;
  logic [15:0] vinLoop1;
  logic        vinAboveOn;
  logic        vinBelowOff;
  logic        uvArmed_q;
  logic        uvFault;
  logic        softOffCause;

  // each loop decodes its own on/off configuration
  // both loops must agree, so one pin runs the whole converter
  assign enableRequest =
    loopRequest(onOffCfgLoop0, enSync2_q, operationOn)
    && loopRequest(onOffCfgLoop1, enSync2_q, operationOn);

  // source select 3 picks the primary sense converter, any other value the alternate
  assign vinLoop1 = (loop1InputSourceSelect == tscs_pkg::SRC_SEL_PRIMARY)
                  ? sense.vinPrimary : sense.vinAlternate;
  assign vinAboveOn  = vinLoop1 > lin11ToQ8(onLevel_q);
  assign vinBelowOff = vinLoop1 < lin11ToQ8(offLevel_q);

  // ****************************************
  // sequencer
  // ****************************************
  tscs_pkg::tscs_state_t state_q;
  tscs_pkg::tscs_state_t state_d;
  logic [31:0] delayCnt_q;
  logic [31:0] delayTarget;
  logic        loop0Started_q;
  logic        voutBelowStop;

  // 10 us steps with fraction, plus a 20 us base
  assign delayTarget =
    ((32'(lin11ToQ8(delayReg_q)) * tscs_pkg::DELAY_STEP_CYC)
      >> tscs_pkg::VOLT_FRAC_BITS) + tscs_pkg::DELAY_BASE_CYC;
  assign voutBelowStop = sense.vout < lin11ToQ8(stopLevel_q);

  // output undervoltage is armed only after the warn level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      uvArmed_q <= 1'b0;
    end else if (state_q == tscs_pkg::SEQ_IDLE
                 || state_q == tscs_pkg::SEQ_FAULT) begin
      uvArmed_q <= 1'b0;
    end else if (sense.vout > sense.voutUvWarn) begin
      uvArmed_q <= 1'b1;
    end
  end

  assign uvFault = inputUvFault || (voutUvRaw && uvArmed_q);
  // off request or low input; undervoltage goes soft
  assign softOffCause = !enableRequest || vinBelowOff || uvFault;

  always_comb begin
    state_d = state_q;
    // hard fault wins from any state
    if (faultShutdown) begin
      state_d = tscs_pkg::SEQ_FAULT;
    end else begin
      unique case (state_q)
        tscs_pkg::SEQ_IDLE: begin
          // all enables, input level, no fault
          if (enableRequest && vinAboveOn && !uvFault) begin
            state_d = tscs_pkg::SEQ_RAMP;
          end
        end
        tscs_pkg::SEQ_RAMP: begin
          if (softOffCause) begin
            state_d = tscs_pkg::SEQ_SOFT_OFF;
          // counter reads k-1 in the k-th ramp cycle, so the rise lands on k
          end else if (delayCnt_q + 32'h0000_0001 >= delayTarget) begin
            state_d = tscs_pkg::SEQ_ON;
          end
        end
        tscs_pkg::SEQ_ON: begin
          if (softOffCause) begin
            state_d = tscs_pkg::SEQ_SOFT_OFF;
          end
        end
        tscs_pkg::SEQ_SOFT_OFF: begin
          // switching ends once output is below stop level
          if (voutBelowStop) begin
            state_d = tscs_pkg::SEQ_IDLE;
          end
        end
        tscs_pkg::SEQ_FAULT: begin
          // stays down until software or pin withdraws the request
          if (!enableRequest) begin
            state_d = tscs_pkg::SEQ_IDLE;
          end
        end
        default: state_d = tscs_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= tscs_pkg::SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      delayCnt_q <= 32'h0000_0000;
    end else if (state_q == tscs_pkg::SEQ_RAMP) begin
      delayCnt_q <= delayCnt_q + 32'h0000_0001;
    end else begin
      delayCnt_q <= 32'h0000_0000;
    end
  end

  // second stage starts at the midpoint level, then stays on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loop0Started_q <= 1'b0;
    end else if (state_d == tscs_pkg::SEQ_IDLE
                 || state_d == tscs_pkg::SEQ_FAULT) begin
      loop0Started_q <= 1'b0;
    end else if (sense.vmid >= tscs_pkg::LOOP0_ON_LEVEL) begin
      loop0Started_q <= 1'b1;
    end
  end

  // outputs registered from the next state, so they track state_q exactly
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drive <= '0;
    end else begin
      drive.hotSwapEnableOut <= state_d == tscs_pkg::SEQ_ON;
      drive.loop1Run <= state_d == tscs_pkg::SEQ_RAMP
                     || state_d == tscs_pkg::SEQ_ON
                     || state_d == tscs_pkg::SEQ_SOFT_OFF;
      // both stages keep switching during soft off
      drive.loop0Run <= state_d == tscs_pkg::SEQ_SOFT_OFF
                     || ((state_d == tscs_pkg::SEQ_RAMP
                          || state_d == tscs_pkg::SEQ_ON)
                         && (loop0Started_q
                             || sense.vmid >= tscs_pkg::LOOP0_ON_LEVEL));
      // forced duty discharges the output
      drive.loop0ForceDuty <= state_d == tscs_pkg::SEQ_SOFT_OFF;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_HS_ONLY_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
    drive.hotSwapEnableOut |-> state_q == tscs_pkg::SEQ_ON
      && !$past(faultShutdown))
    else $error("hot-swap enable outside on state");
  AST_HS_AFTER_DELAY: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(drive.hotSwapEnableOut)
      |-> $past(delayCnt_q) + 32'h0000_0001 >= $past(delayTarget))
    else $error("hot-swap enable before delay");
  AST_PWM_FIRST: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(drive.hotSwapEnableOut) |-> $past(drive.loop1Run, 2))
    else $error("hot-swap enable before first stage");
  AST_FAULT_ALL_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    faultShutdown |=> drive == '0)
    else $error("outputs not off after fault");
  AST_SOFT_FORCED: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == tscs_pkg::SEQ_SOFT_OFF |-> drive.loop0ForceDuty
      && drive.loop1Run && drive.loop0Run && !drive.hotSwapEnableOut)
    else $error("soft off drive wrong");
  AST_STOP_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == tscs_pkg::SEQ_SOFT_OFF && voutBelowStop
      |=> !drive.loop1Run && !drive.loop0Run)
    else $error("switching not stopped at stop level");
  AST_OFF_REQUEST: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == tscs_pkg::SEQ_ON && (!enableRequest || vinBelowOff))
      |=> !drive.hotSwapEnableOut)
    else $error("hot-swap not dropped on disable");
  AST_DUTY_CALC: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdValid && cmdWrite && cmdCode == tscs_pkg::CMD_DUTY_LIMIT && !cfgLoad
      |=> ##1 loop1ForcedDuty == 16'(32'(lin11ToQ8($past(cmdWdata, 2)))
                                     / tscs_pkg::DUTY_SCALE_PCT))
    else $error("forced duty not recomputed");
  AST_FREQ_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    freqWrite |=> loop1Freq == $past(freqValue))
    else $error("frequency not updated");
  AST_UV_MASKED: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == tscs_pkg::SEQ_ON && !uvArmed_q && voutUvRaw && !inputUvFault
      && enableRequest && !vinBelowOff && !faultShutdown
      |=> state_q == tscs_pkg::SEQ_ON)
    else $error("undervoltage acted before armed");

endmodule

// *** rtl/tscs_pkg.sv ***
package tscs_pkg;

  // ****************************************
  // command codes and power-up values
  // ****************************************
  localparam logic [7:0]  CMD_EFUSE_ON_LEVEL  = 8'hB1;
  localparam logic [7:0]  CMD_EFUSE_OFF_LEVEL = 8'hB2;
  localparam logic [7:0]  CMD_PWM_STOP_LEVEL  = 8'hE5;
  localparam logic [7:0]  CMD_EFUSE_DELAY     = 8'hE8;
  localparam logic [7:0]  CMD_DUTY_LIMIT      = 8'hED;
  localparam logic [15:0] RST_EFUSE_ON_LEVEL  = 16'hF0B0;
  localparam logic [15:0] RST_EFUSE_OFF_LEVEL = 16'hF0A8;
  localparam logic [15:0] RST_PWM_STOP_LEVEL  = 16'hA333;
  localparam logic [15:0] RST_EFUSE_DELAY     = 16'h0000;
  localparam logic [15:0] RST_DUTY_LIMIT      = 16'hF170;
  localparam logic [15:0] RST_LOOP1_FREQ      = 16'h093B;

  // ****************************************
  // on/off configuration fields
  // ****************************************
  localparam int CFG_RESPOND_BIT  = 4;
  localparam int CFG_USE_OP_BIT   = 3;
  localparam int CFG_USE_PIN_BIT  = 2;
  localparam int CFG_POLARITY_BIT = 1;
  localparam logic [1:0] SRC_SEL_PRIMARY = 2'h3;

  // ****************************************
  // levels in volts, 8 fractional bits
  // ****************************************
  localparam int          VOLT_FRAC_BITS   = 8;
  localparam logic [15:0] LOOP0_ON_LEVEL   = 16'h0300;
  localparam int          DUTY_SCALE_PCT   = 100;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 50;
  localparam int DELAY_STEP_US  = 10;
  localparam int DELAY_BASE_US  = 20;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
  localparam int DELAY_BASE_CYC = DELAY_BASE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_RAMP, SEQ_ON, SEQ_SOFT_OFF, SEQ_FAULT
  } tscs_state_t;

  typedef struct packed {
    logic [15:0] vinPrimary;
    logic [15:0] vinAlternate;
    logic [15:0] vmid;
    logic [15:0] vout;
    logic [15:0] voutUvWarn;
  } tscs_sense_t;

  typedef struct packed {
    logic hotSwapEnableOut;
    logic loop1Run;
    logic loop0Run;
    logic loop0ForceDuty;
  } tscs_drive_t;

endpackage

// *** sim/tscs_plant_model.sv ***
`timescale 1ns/1ps
// ****************************************
// hot-swap switch and power stages
// ****************************************
module tscs_plant_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire tscs_pkg::tscs_drive_t drive,
  output logic [15:0]                vmid,
  output logic [15:0]                vout
);
  // coarse ramps: slow enough that thresholds are crossed in clean steps
  localparam logic [15:0] STEP     = 16'h0010;
  localparam logic [15:0] VMID_TOP = 16'h1800;
  localparam logic [15:0] VOUT_TOP = 16'h0C00;

  // enable is taken as a driven level, there is no pull-up to fall back on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vmid <= 16'h0000;
    end else if (drive.hotSwapEnableOut && drive.loop1Run) begin
      vmid <= (vmid < VMID_TOP) ? vmid + STEP : vmid;
    end else begin
      vmid <= (vmid > STEP) ? vmid - STEP : 16'h0000;
    end
  end

  // forced duty discharges the output instead of regulating it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vout <= 16'h0000;
    end else if (drive.loop0Run && !drive.loop0ForceDuty) begin
      vout <= (vout < VOUT_TOP) ? vout + STEP : vout;
    end else begin
      vout <= (vout > STEP) ? vout - STEP : 16'h0000;
    end
  end
endmodule

// *** sim/two_stage_converter_sequencer_tb.sv ***
`timescale 1ns/1ps
module two_stage_converter_sequencer_tb;
  logic                  clk_sys, rstn, pinEn, opOn, faultSd, inUv;
  logic                  uvRaw, cfgLoad, freqWrite, cmdValid, cmdWrite;
  logic                  cmdAck, cmdUnsupported;
  logic [7:0]            cmdCode;
  logic [1:0]            srcSel;
  logic [15:0]           vinP, vinA, cmdWdata, cmdRdata, duty, freq;
  logic [15:0]           cfgDuty, freqVal, vmid, vout;
  logic [3:0]            dv;
  tscs_pkg::tscs_drive_t drv;
  tscs_pkg::tscs_sense_t sense;
  int                    num_errors, checks_done;

  assign sense = {vinP, vinA, vmid, vout, 16'h0A00};
  assign dv    = drv;

  tscs_sequencer uut (
    .clk_sys(clk_sys), .rstn(rstn), .converterEnablePin(pinEn),
    .operationOn(opOn), .onOffCfgLoop0(8'h1F), .onOffCfgLoop1(8'h1A),
    .loop1InputSourceSelect(srcSel), .sense(sense),
    .faultShutdown(faultSd), .inputUvFault(inUv), .voutUvRaw(uvRaw),
    .cfgLoad(cfgLoad), .cfgDutyLimit(cfgDuty), .freqWrite(freqWrite),
    .freqValue(freqVal), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdAck(cmdAck),
    .cmdUnsupported(cmdUnsupported), .cmdRdata(cmdRdata), .drive(drv),
    .loop1ForcedDuty(duty), .loop1Freq(freq));

  tscs_plant_model plant (
    .clk_sys(clk_sys), .rstn(rstn), .drive(drv), .vmid(vmid), .vout(vout));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  // word in signed 5-bit exponent, 11-bit mantissa form, as 1/256 units
  function automatic int lin_q8(input logic [15:0] w);
    int m;
    int e;
    m = $signed(w[10:0]);
    e = $signed(w[15:11]);
    m = m * 256;
    return (e < 0) ? (m >>> (-e)) : (m <<< e);
  endfunction

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a wait that runs out of cycles is a mismatch and ends the run
  task automatic give_up(input logic [31:0] got, input logic [31:0] exp);
    num_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    tally_and_finish();
  endtask

  task automatic wait_drive(input int idx, input logic val, input int lim,
                            output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge clk_sys);
      #1;
      if (dv[idx] === val) return;
    end
    give_up(dv[idx], val);
  endtask

  task automatic settle();
    for (int n = 0; n < 600 && (vmid | vout) !== 16'h0000; n++) begin
      @(posedge clk_sys);
    end
    if ((vmid | vout) !== 16'h0000) begin
      give_up(vmid | vout, 16'h0000);
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic wr, input logic [7:0] code,
                     input logic [15:0] wd, output logic [15:0] rd,
                     output logic ok);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode  <= code;
    cmdWdata <= wd;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    #1;
    for (int k = 0; k < 3; k++) begin
      if (cmdAck === 1'b1 || cmdUnsupported === 1'b1) break;
      @(posedge clk_sys);
      #1;
    end
    if (cmdAck !== 1'b1 && cmdUnsupported !== 1'b1) begin
      give_up(cmdAck, 1'b1);
    end
    ok = cmdAck;
    rd = cmdRdata;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_duty();
    logic [15:0] rd;
    logic        ok;
    check(dv, 4'b0000);
    check(freq, tscs_pkg::RST_LOOP1_FREQ);
    check(duty, lin_q8(tscs_pkg::RST_DUTY_LIMIT) / 100);
    cmd(1'b1, tscs_pkg::CMD_DUTY_LIMIT, 16'hF190, rd, ok);
    repeat (2) @(posedge clk_sys);
    #1;
    check(duty, lin_q8(16'hF190) / 100);
    @(posedge clk_sys);
    cfgLoad   <= 1'b1;
    cfgDuty   <= 16'hF0C8;
    @(posedge clk_sys);
    cfgLoad   <= 1'b0;
    freqWrite <= 1'b1;
    freqVal   <= 16'h087D;
    @(posedge clk_sys);
    freqWrite <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check(duty, lin_q8(16'hF0C8) / 100);
    check(freq, 16'h087D);
    cmd(1'b1, tscs_pkg::CMD_DUTY_LIMIT, tscs_pkg::RST_DUTY_LIMIT, rd, ok);
  endtask

  task automatic t_regs();
    logic [7:0]  codes [5];
    logic [15:0] rsts  [5];
    logic [15:0] rd;
    logic        ok;
    codes = '{tscs_pkg::CMD_EFUSE_ON_LEVEL, tscs_pkg::CMD_EFUSE_OFF_LEVEL,
              tscs_pkg::CMD_PWM_STOP_LEVEL, tscs_pkg::CMD_EFUSE_DELAY,
              tscs_pkg::CMD_DUTY_LIMIT};
    rsts  = '{tscs_pkg::RST_EFUSE_ON_LEVEL, tscs_pkg::RST_EFUSE_OFF_LEVEL,
              tscs_pkg::RST_PWM_STOP_LEVEL, tscs_pkg::RST_EFUSE_DELAY,
              tscs_pkg::RST_DUTY_LIMIT};
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, codes[i], 16'h0000, rd, ok);
      check({ok, rd}, {1'b1, rsts[i]});
      cmd(1'b1, codes[i], 16'h5A00 + 16'(i), rd, ok);
      cmd(1'b0, codes[i], 16'h0000, rd, ok);
      check(rd, 16'h5A00 + 16'(i));
      cmd(1'b1, codes[i], rsts[i], rd, ok);
    end
    cmd(1'b1, 8'hB3, 16'hFFFF, rd, ok);
    cmd(1'b0, 8'hB3, 16'h0000, rd, ok);
    check({ok, cmdUnsupported, rd}, 18'h1_0000);
  endtask

  task automatic t_refuse();
    logic [15:0] vin [4];
    logic [15:0] alt [4];
    logic [1:0]  req [4];
    logic [3:0]  seen;
    vin  = '{16'h2C00, 16'h3000, 16'h3000, 16'h3000};
    alt  = '{16'h3000, 16'h3000, 16'h3000, 16'h2C00};
    req  = '{2'b11, 2'b01, 2'b10, 2'b11};
    for (int i = 0; i < 4; i++) begin
      // operation off while the pin passes its synchroniser
      opOn  <= 1'b0;
      pinEn <= req[i][1];
      repeat (3) @(posedge clk_sys);
      vinP   <= vin[i];
      vinA   <= alt[i];
      srcSel <= (i == 3) ? 2'h0 : tscs_pkg::SRC_SEL_PRIMARY;
      opOn   <= req[i][0];
      seen = 4'b0000;
      repeat (50) begin
        @(posedge clk_sys);
        #1;
        seen = seen | dv;
      end
      check(seen, 4'b0000);
    end
    srcSel <= tscs_pkg::SRC_SEL_PRIMARY;
    vinA  <= 16'h0000;
    vinP  <= 16'h3000;
    pinEn <= 1'b1;
    opOn  <= 1'b0;
    settle();
  endtask

  task automatic t_run(input int cause);
    int          n;
    int          dlyCyc;
    logic [15:0] dly;
    logic [15:0] rd;
    logic        ok;
    dly    = (cause == 1) ? 16'hF805 : 16'h0000;
    dlyCyc = ((lin_q8(dly) * 500) >>> 8) + 1000;
    cmd(1'b1, tscs_pkg::CMD_EFUSE_DELAY, dly, rd, ok);
    uvRaw <= (cause == 4);
    opOn  <= 1'b1;
    wait_drive(2, 1'b1, 10, n);
    check(dv, 4'b0100);
    wait_drive(3, 1'b1, 3000, n);
    check(n + 1, dlyCyc);
    check(dv, 4'b1100);
    wait_drive(1, 1'b1, 100, n);
    check(32'((vmid >= 16'h0300) && (vmid <= 16'h0340)), 1);
    if (cause == 4) begin
      wait_drive(3, 1'b0, 400, n);
      check(32'(vout > 16'h0A00), 1);
    end else begin
      for (n = 0; n < 400 && vout !== 16'h0C00; n++) begin
        @(posedge clk_sys);
      end
      if (vout !== 16'h0C00) begin
        give_up(vout, 16'h0C00);
      end
      case (cause)
        0: opOn <= 1'b0;
        1: vinP <= 16'h2800;
        2: inUv <= 1'b1;
        default: pinEn <= 1'b0;
      endcase
      wait_drive(3, 1'b0, 6, n);
    end
    check(dv, 4'b0111);
    wait_drive(2, 1'b0, 400, n);
    check(32'((vout < 16'h0033) && (vout >= 16'h0010)), 1);
    check(dv, 4'b0000);
    opOn  <= 1'b0;
    pinEn <= 1'b1;
    vinP  <= 16'h3000;
    inUv  <= 1'b0;
    uvRaw <= 1'b0;
    settle();
  endtask

  task automatic t_fault();
    int n;
    opOn    <= 1'b1;
    wait_drive(1, 1'b1, 1500, n);
    faultSd <= 1'b1;
    wait_drive(3, 1'b0, 3, n);
    check(dv, 4'b0000);
    repeat (20) @(posedge clk_sys);
    #1;
    check(dv, 4'b0000);
    opOn    <= 1'b0;
    faultSd <= 1'b0;
    settle();
  endtask

  initial begin
    rstn        = 1'b0;
    pinEn       = 1'b1;
    opOn        = 1'b0;
    faultSd     = 1'b0;
    inUv        = 1'b0;
    uvRaw       = 1'b0;
    cfgLoad     = 1'b0;
    freqWrite   = 1'b0;
    cmdValid    = 1'b0;
    cmdWrite    = 1'b0;
    cmdCode     = 8'h00;
    cmdWdata    = 16'h0000;
    cfgDuty     = 16'h0000;
    freqVal     = 16'h0000;
    vinP        = 16'h3000;
    vinA        = 16'h0000;
    srcSel      = tscs_pkg::SRC_SEL_PRIMARY;
    num_errors  = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_duty();
    t_regs();
    t_refuse();
    for (int c = 0; c < 5; c++) begin
      t_run(c);
    end
    t_fault();
    tally_and_finish();
  end
endmodule
